// [bench/counter_mode_sequencer_props.sv]
// Checker of the mode sequencer's port behaviour.
// Assumes it is bound into counter_mode_sequencer and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
`include "cnt_mode_defs.vh"
module cms_props #(
  parameter WIDTH = `CNT_WIDTH
) (
  input wire logic             ref_clk_in,
  input wire logic             reset_n_in,
  input wire logic [2:0]       gate_ctrl_in,
  input wire logic             special_gate_in,
  input wire logic             reload_src_in,
  input wire logic             repetition_in,
  input wire logic             toggle_on_terminal_count_in,
  input wire logic [WIDTH-1:0] load_value_in,
  input wire logic [WIDTH-1:0] hold_value_in,
  input wire logic             arm_cmd_in,
  input wire logic             disarm_cmd_in,
  input wire logic             load_cmd_in,
  input wire logic [WIDTH-1:0] count_out,
  input wire logic             terminal_count_out,
  input wire logic             counter_pin_out,
  input wire logic             armed_out,
  input wire logic             triggered_out,
  input wire logic             second_phase_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  AST_HOLD: assert property (
    !armed_out && !terminal_count_out && !arm_cmd_in && !load_cmd_in |=> $stable(count_out))
    else $error("count moved while disarmed");
  AST_RELOAD: assert property (
    $rose(terminal_count_out) && !(reload_src_in && second_phase_out)
      |-> count_out == load_value_in)
    else $error("terminal count did not reload from load");
  AST_HOLD_FIRST: assert property (
    $rose(terminal_count_out) && reload_src_in && second_phase_out |-> count_out == hold_value_in)
    else $error("first terminal count did not reload from hold");
  AST_DISARM: assert property (
    $rose(terminal_count_out) && !repetition_in && !(reload_src_in && second_phase_out)
      && !$past(arm_cmd_in) |-> !armed_out)
    else $error("terminal count left the counter armed");
  AST_REP: assert property (
    $rose(terminal_count_out) && repetition_in |-> armed_out)
    else $error("repeating mode disarmed");
  AST_TOGGLE: assert property (
    toggle_on_terminal_count_in && $past(toggle_on_terminal_count_in) && $rose(terminal_count_out)
      |-> counter_pin_out != $past(counter_pin_out))
    else $error("output did not invert on terminal count");
  AST_PIN_TC: assert property (
    !toggle_on_terminal_count_in && !$past(toggle_on_terminal_count_in)
      |-> counter_pin_out == terminal_count_out)
    else $error("output differs from terminal count");
  AST_LEAVE: assert property (
    $fell(terminal_count_out) && !$past(load_cmd_in) |-> count_out == $past(count_out) - 1'b1)
    else $error("terminal count left without one count");
  AST_EDGE_IDLE: assert property (
    gate_ctrl_in == `GATE_EDGE && !armed_out |=> !triggered_out)
    else $error("gate edge taken while disarmed");
  AST_CMD: assert property (
    disarm_cmd_in |=> !armed_out && !triggered_out ##1 !armed_out || arm_cmd_in)
    else $error("disarm command not obeyed");
  COV_HOLD: cover property ($rose(terminal_count_out) && reload_src_in && second_phase_out);
  COV_TRIG: cover property ($rose(triggered_out));
  COV_REP: cover property ($rose(terminal_count_out) && repetition_in);
endmodule // cms_props
bind counter_mode_sequencer cms_props #(.WIDTH(WIDTH)) cms_props_i (.*);
`default_nettype wire

// [bench/counter_mode_sequencer_tb.sv]
// Self-checking bench for the counter mode sequencer, modes A to H.
// Assumes src_pulser drives the source pin and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
`include "cnt_mode_defs.vh"
module counter_mode_sequencer_tb;
  localparam logic [2:0] ARM = 3'h1;
  localparam logic [2:0] LDC = 3'h4;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        en = 1'b0;
  logic        gate = 1'b0;
  logic        sg = 1'b0;
  logic        rs = 1'b0;
  logic        rep = 1'b0;
  logic        tog = 1'b0;
  logic        tgl = 1'b0;
  logic [2:0]  gc = 3'h0;
  logic [2:0]  cmds = 3'h0;
  logic [15:0] ld = 16'h0002;
  logic [15:0] hd = 16'h0002;
  logic [15:0] lf = 16'he186;
  logic [15:0] cnt;
  logic        src, tc, pin, armed, trig, sec, uns;
  int          num_errors = 0;
  int          tests_run = 0;
  always #4 clk = ~clk;
  src_pulser src_pulser_i (.ref_clk_in(clk), .en_in(en), .source_out(src));
  counter_mode_sequencer counter_mode_sequencer_i (
    .ref_clk_in(clk), .reset_n_in(rst_n), .source_in(src), .gate_in(gate),
    .gate_ctrl_in(gc), .special_gate_in(sg), .reload_src_in(rs), .repetition_in(rep),
    .toggle_on_terminal_count_in(tog), .load_value_in(ld), .hold_value_in(hd),
    .arm_cmd_in(cmds[0]), .disarm_cmd_in(cmds[1]), .load_cmd_in(cmds[2]),
    .count_out(cnt), .terminal_count_out(tc), .counter_pin_out(pin), .armed_out(armed),
    .triggered_out(trig), .second_phase_out(sec), .mode_unsupported_out(uns));
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic uns_exp(input logic [3:0] k);
    return k[3] || !(k[2:0] inside {`GATE_NONE, `GATE_LEVEL, `GATE_EDGE});
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmd(input logic [2:0] c);
    @(posedge clk) cmds <= c;
    @(posedge clk) cmds <= 3'h0;
    cyc(2);
  endtask
  task automatic pulses(input int n);
    @(posedge clk) en <= 1'b1;
    cyc(4 * n);
    en <= 1'b0;
    cyc(6);
  endtask
  task automatic gset(input logic v);
    @(posedge clk) gate <= v;
    cyc(4);
  endtask
  task automatic mode(input logic [2:0] g, input logic r, input logic p);
    @(posedge clk) gc <= g;
    rs <= r;
    rep <= p;
    cyc(2);
  endtask
  task automatic fresh;
    lf = nxt(lf);
    @(posedge clk) ld <= 16'h0002 + lf[2:0];
    hd <= 16'h0002 + lf[5:3];
    cmd(LDC);
    chk("load", cnt, ld);
  endtask
  // Reach terminal count after n pulses, then leave it with one more
  task automatic hit(input int n, input logic [15:0] v, input logic a);
    pulses(n);
    tgl = ~tgl;
    chk("terminal_count", tc, 16'h0001);
    chk("count_reload", cnt, v);
    chk("armed", armed, a);
    chk("pin", pin, tog ? tgl : 1'b1);
    pulses(1);
    chk("count_left", cnt, v - 16'h0001);
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    num_errors++;
    results();
  end
  initial begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(2);
    fresh();
    pulses(2);
    chk("count_unarmed", cnt, ld);
    cmd(ARM);
    hit(ld, ld, 1'b0);
    pulses(2);
    chk("count_disarmed", cnt, ld - 16'h0001);
    mode(`GATE_LEVEL, 1'b0, 1'b0);
    fresh();
    cmd(ARM);
    pulses(2);
    chk("count_gate_low", cnt, ld);
    gset(1'b1);
    hit(ld, ld, 1'b0);
    gset(1'b0);
    mode(`GATE_EDGE, 1'b0, 1'b0);
    fresh();
    gset(1'b1);
    gset(1'b0);
    chk("trig_disarmed", trig, 16'h0000);
    // arm first, then the gate edge
    cmd(ARM);
    pulses(2);
    chk("count_untrig", cnt, ld);
    gset(1'b1);
    chk("triggered", trig, 16'h0001);
    gset(1'b0);
    hit(ld, ld, 1'b0);
    @(posedge clk) tog <= 1'b1;
    mode(`GATE_NONE, 1'b0, 1'b1);
    fresh();
    cmd(ARM);
    hit(ld, ld, 1'b1);
    hit(ld - 1, ld, 1'b1);
    cmd(3'h3);
    chk("armed_after_disarm", armed, 16'h0000);
    mode(`GATE_LEVEL, 1'b0, 1'b1);
    fresh();
    cmd(ARM);
    pulses(2);
    chk("count_gate_low_rep", cnt, ld);
    gset(1'b1);
    hit(ld, ld, 1'b1);
    gset(1'b0);
    mode(`GATE_EDGE, 1'b0, 1'b1);
    fresh();
    cmd(ARM);
    gset(1'b1);
    gset(1'b0);
    pulses(1);
    gset(1'b1);
    gset(1'b0);
    hit(ld - 1, ld, 1'b1);
    pulses(2);
    chk("count_waiting", cnt, ld - 16'h0001);
    chk("trig_cleared", trig, 16'h0000);
    mode(`GATE_NONE, 1'b1, 1'b0);
    fresh();
    cmd(ARM);
    hit(ld, hd, 1'b1);
    chk("second_phase", sec, 16'h0001);
    hit(hd - 1, ld, 1'b0);
    mode(`GATE_LEVEL, 1'b1, 1'b0);
    fresh();
    cmd(ARM);
    pulses(2);
    chk("count_gate_low_dp", cnt, ld);
    gset(1'b1);
    hit(ld, hd, 1'b1);
    hit(hd - 1, ld, 1'b0);
    gset(1'b0);
    for (int k = 0; k < 16; k++) begin
      @(posedge clk) {sg, gc} <= k[3:0];
      cyc(1);
      chk("unsupported", uns, uns_exp(k[3:0]));
    end
    results();
  end
endmodule // counter_mode_sequencer_tb
`default_nettype wire

// [bench/src_pulser.sv]
// Far-side model of the source pin: pulses two cycles low, two high.
// Assumes en_in changes just after rising edges of ref_clk_in.
`timescale 1ns/100ps
`default_nettype none
module src_pulser (
  input  wire logic ref_clk_in,
  input  wire logic en_in,
  output var  logic source_out
);
  logic [1:0] ph_r;
  always @(posedge ref_clk_in) begin
    ph_r <= en_in ? ph_r + 2'h1 : 2'h0;
  end
  // Pin stays low outside a train, so no stray edge
  assign source_out = en_in & ph_r[1];
endmodule // src_pulser
`default_nettype wire

// [rtl/cnt_mode_defs.vh]
// Constants shared by the counter mode sequencer files.
// Assumes it is included by bare name from files under rtl/ and bench/.
`ifndef CNT_MODE_DEFS_VH
`define CNT_MODE_DEFS_VH

// Counter width default
`define CNT_WIDTH          16

// Gate-control field codes
`define GATE_NONE          3'h0
`define GATE_LEVEL         3'h4
`define GATE_EDGE          3'h6

// Reset values of the channel state
`define CNT_RESET          16'h0000
`define ARMED_RESET        1'b0
`define TRIG_RESET         1'b0
`define SECOND_RESET       1'b0
`define TC_RESET           1'b0
`define TOGGLE_RESET       1'b0

// Counter value on which the next counted edge enters terminal count
`define CNT_LAST           16'h0001

// Kind of gating decoded from the gate-control field
`define KIND_NONE          2'h0
`define KIND_LEVEL         2'h1
`define KIND_EDGE          2'h2
`define KIND_BAD           2'h3

`endif

// [rtl/counter_mode_sequencer.v]
// Mode sequencer for one channel of a counter/timer: modes A to H.
// Assumes command strobes are one-cycle pulses on ref_clk_in and that
// the load and hold values are held stable by the surrounding logic.
//
// Notes on behaviour
// - All mode bits zero: count source edges only once armed, gate ignored.
// - Ungated single strobe: terminal count reloads from load and disarms.
// - Level-gated strobe counts source edges only while gate is active.
// - Level-gated strobe: terminal count reloads from load and disarms.
// - Edge strobe: armed counter starts on first source edge after gate edge.
// - Edge strobe: gate edges while disarmed are ignored.
// - Edge strobe: after trigger, gate level and edges ignored until terminal count.
// - Ungated rate generator repeats counting, reloading from load each time.
// - Toggle option inverts output on each terminal count.
// - Level-gated rate generator counts only while gate is active.
// - One-shot: armed counter starts on gate edge, reloads, stays armed.
// - One-shot stops after terminal count until next gate edge.
// - One-shot ignores gate activity after trigger until terminal count.
// - Software delayed pulse: gate ignored, two terminal counts, then disarm.
// - Delayed pulse: first terminal count after arming reloads from hold.
// - Delayed pulse: second terminal count reloads from load and disarms.
// - Toggle delayed pulse: initial count is delay, hold value is width.
// - Level-gated delayed pulse counts only while gate is active.
// - Level-gated delayed pulse keeps hold-then-load reload order.
// - In terminal-count state next source edge always counts.
// - Mode chosen from gate field plus special, reload and repetition bits.
// - Only active-going source and gate transitions have effect.
`timescale 1ns/100ps
`default_nettype none
`include "cnt_mode_defs.vh"

module counter_mode_sequencer #(
  parameter WIDTH = `CNT_WIDTH
) (
  input  wire             ref_clk_in,
  input  wire             reset_n_in,
  // Pins of the channel
  input  wire             source_in,
  input  wire             gate_in,
  // Mode selection
  input  wire [2:0]       gate_ctrl_in,
  input  wire             special_gate_in,
  input  wire             reload_src_in,
  input  wire             repetition_in,
  input  wire             toggle_on_terminal_count_in,
  // Register contents and commands
  input  wire [WIDTH-1:0] load_value_in,
  input  wire [WIDTH-1:0] hold_value_in,
  input  wire             arm_cmd_in,
  input  wire             disarm_cmd_in,
  input  wire             load_cmd_in,
  // Status and output
  output wire [WIDTH-1:0] count_out,
  output reg              terminal_count_out,
  output reg              counter_pin_out,
  output wire             armed_out,
  output wire             triggered_out,
  output wire             second_phase_out,
  output wire             mode_unsupported_out
);

  // Synchronised pin levels and active-going edges
  wire [1:0] pin_level;
  wire [1:0] pin_rise;
  wire       gate_lvl;
  wire       gate_edge;
  wire       src_edge;

  // Channel state
  reg        armed_r;
  reg        armed_nxt;
  reg        trig_r;
  reg        trig_nxt;
  reg        second_r;
  reg        second_nxt;
  reg        tc_r;
  reg        tc_nxt;
  reg        toggle_r;
  reg        toggle_nxt;

  // Output pin selection
  reg        pin_nxt;

  // Mode decode
  reg  [1:0] gate_kind;
  wire       mode_ok;

  // Counting control
  reg        qualify;
  wire       step;
  wire       reach_tc;
  wire       cnt_at_last;
  wire [WIDTH-1:0] cnt_val;
  reg  [WIDTH-1:0] reload_val;
  reg        reload_en;
  wire       first_tc_pending;

  pin_edge_sync #(
    .WIDTH     (2)
  ) u_pin_sync (
    .clk_in    (ref_clk_in),
    .reset_n_in(reset_n_in),
    .pin_in    ({gate_in, source_in}),
    .level_out (pin_level),
    .rise_out  (pin_rise)
  );

  assign src_edge  = pin_rise[0];
  assign gate_edge = pin_rise[1];
  assign gate_lvl  = pin_level[1];

  // decode of the three gate-control bits
  always @* begin
    case (gate_ctrl_in)
      `GATE_NONE:  gate_kind = `KIND_NONE;
      `GATE_LEVEL: gate_kind = `KIND_LEVEL;
      `GATE_EDGE:  gate_kind = `KIND_EDGE;
      default:     gate_kind = `KIND_BAD;
    endcase
  end

  // Special gating belongs to modes this block does not cover
  assign mode_ok = !special_gate_in && (gate_kind != `KIND_BAD);

  // An edge-gated counter must be triggered before sources count
  always @* begin
    qualify = 1'b0;
    if (armed_r && mode_ok) begin
      case (gate_kind)
        `KIND_NONE:  qualify = 1'b1;
        // level gating qualifies each source edge
        `KIND_LEVEL: qualify = gate_lvl;
        // once triggered the gate level is not looked at
        `KIND_EDGE:  qualify = trig_r;
        default:     qualify = 1'b0;
      endcase
    end
  end

  // the terminal-count state counts regardless of gate and arming
  assign step = src_edge && (tc_r || qualify);

  // The edge counted while already at the last count enters terminal count
  assign reach_tc = step && cnt_at_last;

  // In delayed-pulse modes the first terminal count still awaits
  assign first_tc_pending = reload_src_in && !second_r;

  // Choice of reload register at terminal count
  always @* begin
    reload_val = load_value_in;
    reload_en  = 1'b0;
    if (load_cmd_in) begin
      reload_val = load_value_in;
      reload_en  = 1'b1;
    end else if (reach_tc) begin
      reload_en = 1'b1;
      if (first_tc_pending) begin
        // first terminal count takes the hold register
        reload_val = hold_value_in;
      end else begin
        reload_val = load_value_in;
      end
    end
  end

  down_count_reg #(
    .WIDTH        (WIDTH)
  ) u_count (
    .clk_in       (ref_clk_in),
    .reset_n_in   (reset_n_in),
    .load_in      (reload_en),
    .load_value_in(reload_val),
    .step_in      (step),
    .count_out    (cnt_val),
    .at_last_out  (cnt_at_last)
  );

  // Arming state
  always @* begin
    armed_nxt = armed_r;
    if (disarm_cmd_in) begin
      armed_nxt = 1'b0;
    // repetition keeps the counter armed through terminal count
    end else if (reach_tc && !repetition_in) begin
      if (!reload_src_in) begin
        // strobe modes disarm at terminal count
        armed_nxt = 1'b0;
      end else if (second_r) begin
        // gate has no part in this
        armed_nxt = 1'b0;
      end
    end
    // An arm arriving with a terminal count still wins
    if (arm_cmd_in && !disarm_cmd_in) begin
      armed_nxt = 1'b1;
    end
  end

  // Trigger state for edge-gated modes
  always @* begin
    trig_nxt = trig_r;
    if (disarm_cmd_in || gate_kind != `KIND_EDGE) begin
      trig_nxt = 1'b0;
    end else if (reach_tc && !first_tc_pending) begin
      // one-shot stops and waits for a new gate edge
      trig_nxt = 1'b0;
    end else if (gate_edge && armed_r && !trig_r && !tc_r) begin
      // trigger latched, counting starts on a later source edge
      trig_nxt = 1'b1;
    end
    // while triggered further gate edges change nothing
  end

  // Delayed-pulse phase
  always @* begin
    second_nxt = second_r;
    if (arm_cmd_in || !reload_src_in) begin
      // Each arm restarts with the hold reload first
      second_nxt = 1'b0;
    end else if (reach_tc) begin
      second_nxt = !second_r;
    end
  end

  // Terminal-count state lasts until the next source edge
  always @* begin
    tc_nxt = tc_r;
    if (reach_tc) begin
      tc_nxt = 1'b1;
    end else if (step) begin
      tc_nxt = 1'b0;
    end
  end

  // toggled output flips on every terminal count
  // delay then width in delayed-pulse mode
  always @* begin
    toggle_nxt = toggle_r;
    if (reach_tc) begin
      toggle_nxt = !toggle_r;
    end
  end

  // Arming flag
  // Disarm beats arm; arm beats the disarm of a terminal count
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      armed_r <= `ARMED_RESET;
    end else begin
      armed_r <= armed_nxt;
    end
  end

  // Trigger flag of the edge-gated modes
  // Cleared on leaving an edge mode so a stale trigger never fires
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trig_r <= `TRIG_RESET;
    end else begin
      trig_r <= trig_nxt;
    end
  end

  // Delayed-pulse phase flag
  // Cleared outside delayed-pulse modes so each starts with the hold reload
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      second_r <= `SECOND_RESET;
    end else begin
      second_r <= second_nxt;
    end
  end

  // Terminal-count state
  // Held until the next counted edge, whatever the gate and arming
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tc_r <= `TC_RESET;
    end else begin
      tc_r <= tc_nxt;
    end
  end

  // Toggle flop runs whether or not the pin shows it
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      toggle_r <= `TOGGLE_RESET;
    end else begin
      toggle_r <= toggle_nxt;
    end
  end

  // Pin shows the toggled form or the terminal-count level
  // Taken from next state so the registered pin lines up with the state
  always @* begin
    pin_nxt = tc_nxt;
    if (toggle_on_terminal_count_in) begin
      pin_nxt = toggle_nxt;
    end
  end

  // Terminal-count and pin outputs are registered from next state so they line up with the state and are glitch free
  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      terminal_count_out <= `TC_RESET;
    end else begin
      terminal_count_out <= tc_nxt;
    end
  end

  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      counter_pin_out <= `TC_RESET;
    end else begin
      counter_pin_out <= pin_nxt;
    end
  end

  assign armed_out            = armed_r;
  assign triggered_out        = trig_r;
  assign second_phase_out     = second_r;
  assign count_out            = cnt_val;
  // Only special gating and undefined gate codes are flagged here
  assign mode_unsupported_out = !mode_ok;

endmodule // counter_mode_sequencer

`default_nettype wire

// [rtl/down_count_reg.v]
// Loadable down counter holding one channel's count value.
// Assumes nothing of the caller's timing; a load wins over a step in one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "cnt_mode_defs.vh"

module down_count_reg #(
  parameter WIDTH = `CNT_WIDTH
) (
  input  wire             clk_in,
  input  wire             reset_n_in,
  input  wire             load_in,
  input  wire [WIDTH-1:0] load_value_in,
  input  wire             step_in,
  output wire [WIDTH-1:0] count_out,
  output wire             at_last_out
);

  reg [WIDTH-1:0] cnt_r;
  reg [WIDTH-1:0] cnt_nxt;

  always @* begin
    cnt_nxt = cnt_r;
    if (load_in) begin
      cnt_nxt = load_value_in;
    end else if (step_in) begin
      cnt_nxt = cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= {WIDTH{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count_out = cnt_r;
  // A zero count also terminates so a cleared counter cannot run away
  assign at_last_out = (cnt_r <= {{(WIDTH-1){1'b0}}, 1'b1});

endmodule // down_count_reg

`default_nettype wire

// [rtl/pin_edge_sync.v]
// Two-stage synchroniser with rising-edge detector for pin inputs.
// Assumes the pins are asynchronous to clk_in; edges are one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none

module pin_edge_sync #(
  parameter WIDTH = 2
) (
  input  wire             clk_in,
  input  wire             reset_n_in,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out,
  output wire [WIDTH-1:0] rise_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  reg [WIDTH-1:0] prev_r;

  // Only the second stage and later are looked at
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
      prev_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  // Falling transitions are deliberately not reported
  assign rise_out  = sync_r & ~prev_r;

endmodule // pin_edge_sync

`default_nettype wire
